// ---- design/adcsp_pkg.sv ----
// Purpose: Shared constants for the converter serial port block.
// Assumes: Host-driven serial clock, 10 MHz core clock.
// Notes:
// Summary of operation
// - Output changes on falling, host samples rising.
// - Chip select high floats the output line.
// - Idle selected line drives low on conversion done.
// - Unread result: line returns high before update.
// - Input bits captured on serial clock rising.
// - Input data goes to addressed control register.
// - Read register loads output shifter, shifted out.
// - Configuration bit opens/closes power-down switch.
// - Clock select sets crystal pin role.
package adcsp_pkg;
  // Communications byte fields
  localparam int COMM_WEN_BIT = 7;
  localparam int COMM_RD_BIT = 6;
  localparam int ADDR_W = 6;
  localparam int WORD_W = 24;
  localparam int CNT_W = 5;
  // Register addresses
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_MODE = 6'h01;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_GPIO = 6'h06;
  localparam logic [5:0] ADDR_ID = 6'h07;
  // Register lengths in bits
  localparam logic [4:0] LEN_NONE = 5'h00;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_HALF = 5'h10;
  localparam logic [4:0] LEN_WORD = 5'h18;
  // Field positions and reset values
  localparam int MODE_CLKSEL_LSB = 2;
  localparam int GPIO_POWERDOWN_SWITCH_BIT = 14;
  localparam int STAT_RDY_BIT = 7;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] GPIO_RST = 16'h0000;
  // Arbitrary identity value
  localparam logic [15:0] ID_VALUE = 16'h5A30;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_PERIOD_NS = 100000;
  localparam int READY_LEAD_NS = 5000;
  localparam int CONV_CYCLES = CONV_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LEAD_CYCLES = (READY_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 10;

  typedef enum logic [1:0] {
    ADCSP_CLK_INT = 2'b00,
    ADCSP_CLK_INT_OUT = 2'b01,
    ADCSP_CLK_EXT = 2'b10,
    ADCSP_CLK_XTAL = 2'b11
  } adcsp_clksel_t;

  typedef enum logic [2:0] {
    ADCSP_COMM = 3'b001,
    ADCSP_WDATA = 3'b010,
    ADCSP_RDATA = 3'b100
  } adcsp_phase_t;

  // Bit length of an addressed register, zero when unmapped
  function automatic logic [4:0] adcsp_reg_len(input logic [5:0] addr);
    logic [4:0] len;
    len = LEN_NONE;
    if (addr == ADDR_STATUS)
    begin
      len = LEN_BYTE;
    end
    else if (addr == ADDR_DATA)
    begin
      len = LEN_WORD;
    end
    else if (addr == ADDR_MODE || addr == ADDR_GPIO || addr == ADDR_ID)
    begin
      len = LEN_HALF;
    end
    return len;
  endfunction : adcsp_reg_len
endpackage : adcsp_pkg

// ---- design/adcsp_sync.sv ----
// Purpose: Two-flop level synchroniser, per bit.
// Assumes: Levels change slowly compared to the clock.
// Notes: First stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module adcsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : adcsp_sync
`default_nettype wire

// ---- design/adcsp_clkpin.sv ----
// Purpose: Role of the crystal/clock pin from clock select.
// Assumes: Select arrives already synchronised.
// Notes: Clock out is core clock divided by two.
`timescale 1ns/100ps
`default_nettype none
module adcsp_clkpin
  import adcsp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Selection
  input wire logic [1:0] clock_source_select,
  // Pin and oscillator controls
  output logic crystal_clock_pin_o,
  output logic crystal_clock_pin_oe,
  output logic crystal_amp_en,
  output logic ext_clk_sel
);
  logic div_q;
  logic oe_q;
  logic amp_q;
  logic ext_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 1'b0;
    end
    else if (ce)
    begin
      div_q <= ~div_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      oe_q <= 1'b0;
      amp_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else if (ce)
    begin
      oe_q <= (clock_source_select == ADCSP_CLK_INT_OUT);
      amp_q <= (clock_source_select == ADCSP_CLK_XTAL);
      ext_q <= (clock_source_select == ADCSP_CLK_EXT);
    end
  end

  assign crystal_clock_pin_o = div_q & oe_q;
  assign crystal_clock_pin_oe = oe_q;
  assign crystal_amp_en = amp_q;
  assign ext_clk_sel = ext_q;
endmodule : adcsp_clkpin
`default_nettype wire

// ---- design/adcsp_top.sv ----
// Purpose: Serial host port with shared data/ready output line.
// Assumes: Host drives serial clock, idle high; new result each period.
// Notes: Registers live on the serial clock; core sees them synchronised.
`timescale 1ns/100ps
`default_nettype none
module adcsp_top
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  // Conversion result from the filter
  input wire logic [adcsp_pkg::WORD_W-1:0] conv_result,
  // Analog and clock controls
  output logic powerdown_switch,
  output logic crystal_clock_pin_o,
  output logic crystal_clock_pin_oe,
  output logic crystal_amp_en,
  output logic ext_clk_sel
);
  import adcsp_pkg::*;

  // Serial clock domain
  adcsp_phase_t phase_q;
  logic [CNT_W-1:0] cnt_q;
  logic [6:0] comm_sh_q;
  logic [WORD_W-1:0] in_sh_q;
  logic [ADDR_W-1:0] addr_q;
  logic [4:0] len_q;
  logic [15:0] converter_mode_reg_q;
  logic [15:0] gpio_config_reg_q;
  logic rd_tog_q;
  logic busy_q;
  logic [WORD_W-1:0] out_sh_q;
  logic rd_drive_q;
  logic frame_rst;
  logic [7:0] comm_byte;
  logic [WORD_W-1:0] wr_word;
  logic [WORD_W-1:0] rd_word;
  logic [1:0] s_sync;
  logic ready_n_s;
  logic ce_s;

  // Core clock domain
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic [WORD_W-1:0] data_hold_q;
  logic ready_n_q;
  logic upd_pend_q;
  logic rd_tog_seen_q;
  logic [4:0] c_sync;
  logic rd_tog_c;
  logic busy_c;
  logic powerdown_switch_c;
  logic [1:0] clksel_c;
  logic powerdown_switch_q;
  logic conv_wrap;
  logic lead_hit;
  logic rd_event;
  logic do_update;

  assign frame_rst = rst | cs_n;
  assign comm_byte = {comm_sh_q, din};
  assign wr_word = {in_sh_q[WORD_W-2:0], din};

  // Core-domain ready and clock enable onto the serial clock
  adcsp_sync #(
    .WIDTH(2)
  ) u_sync_s (
    .clk(sclk),
    .rst(rst),
    .ce(1'b1),
    .d({ready_n_q, ce}),
    .q(s_sync)
  );
  assign ready_n_s = s_sync[1];
  assign ce_s = s_sync[0];

  always_ff @(posedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      phase_q <= ADCSP_COMM;
      cnt_q <= '0;
      comm_sh_q <= '0;
      in_sh_q <= '0;
      addr_q <= '0;
      len_q <= LEN_NONE;
      busy_q <= 1'b0;
    end
    else if (ce_s)
    begin
      unique case (phase_q)
        ADCSP_COMM:
        begin
          comm_sh_q <= comm_byte[6:0];
          if (cnt_q == CNT_W'(7))
          begin
            cnt_q <= '0;
            addr_q <= comm_byte[ADDR_W-1:0];
            len_q <= adcsp_reg_len(comm_byte[ADDR_W-1:0]);
            if (comm_byte[COMM_WEN_BIT] || adcsp_reg_len(comm_byte[ADDR_W-1:0]) == LEN_NONE)
            begin
              phase_q <= ADCSP_COMM;
              busy_q <= 1'b0;
            end
            else if (comm_byte[COMM_RD_BIT])
            begin
              phase_q <= ADCSP_RDATA;
              busy_q <= 1'b1;
            end
            else
            begin
              phase_q <= ADCSP_WDATA;
              busy_q <= 1'b1;
            end
          end
          else
          begin
            cnt_q <= cnt_q + CNT_W'(1);
            busy_q <= 1'b1;
          end
        end
        // Input shifter also runs in reads, unused there
        ADCSP_WDATA, ADCSP_RDATA:
        begin
          in_sh_q <= wr_word;
          if (cnt_q == len_q - 5'h01)
          begin
            cnt_q <= '0;
            phase_q <= ADCSP_COMM;
            busy_q <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default:
        begin
          phase_q <= ADCSP_COMM;
          cnt_q <= '0;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      converter_mode_reg_q <= MODE_RST;
      gpio_config_reg_q <= GPIO_RST;
    end
    else if (ce_s && !cs_n && phase_q == ADCSP_WDATA && cnt_q == len_q - 5'h01)
    begin
      if (addr_q == ADDR_MODE)
      begin
        converter_mode_reg_q <= wr_word[15:0];
      end
      if (addr_q == ADDR_GPIO)
      begin
        gpio_config_reg_q <= wr_word[15:0];
      end
    end
  end

  // Data read event toward the core
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      rd_tog_q <= 1'b0;
    end
    else if (ce_s && !cs_n && phase_q == ADCSP_COMM && cnt_q == CNT_W'(7) && !comm_byte[COMM_WEN_BIT]
             && comm_byte[COMM_RD_BIT] && comm_byte[ADDR_W-1:0] == ADDR_DATA)
    begin
      rd_tog_q <= ~rd_tog_q;
    end
  end

  // Left-aligned read word by address
  always_comb
  begin
    case (addr_q)
      ADDR_STATUS: rd_word = WORD_W'(ready_n_s) << (WORD_W - 8 + STAT_RDY_BIT);
      ADDR_MODE: rd_word = {converter_mode_reg_q, 8'h00};
      ADDR_GPIO: rd_word = {gpio_config_reg_q, 8'h00};
      ADDR_ID: rd_word = {ID_VALUE, 8'h00};
      ADDR_DATA: rd_word = data_hold_q;
      default: rd_word = '0;
    endcase
  end

  always_ff @(negedge sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      out_sh_q <= '0;
      rd_drive_q <= 1'b0;
    end
    else if (ce_s)
    begin
      rd_drive_q <= (phase_q == ADCSP_RDATA);
      if (phase_q == ADCSP_RDATA && !rd_drive_q)
      begin
        out_sh_q <= rd_word;
      end
      else
      begin
        out_sh_q <= {out_sh_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  assign dout_oe = ~cs_n;
  assign dout_o = (rd_drive_q && phase_q == ADCSP_RDATA) ? out_sh_q[WORD_W-1] : ready_n_q;

  // Serial-domain levels into the core
  adcsp_sync #(
    .WIDTH(5)
  ) u_sync_c (
    .clk(core_clk),
    .rst(rst),
    .ce(ce),
    .d({rd_tog_q, busy_q, gpio_config_reg_q[GPIO_POWERDOWN_SWITCH_BIT],
        converter_mode_reg_q[MODE_CLKSEL_LSB+1:MODE_CLKSEL_LSB]}),
    .q(c_sync)
  );
  assign rd_tog_c = c_sync[4];
  assign busy_c = c_sync[3];
  assign powerdown_switch_c = c_sync[2];
  assign clksel_c = c_sync[1:0];

  assign conv_wrap = (conv_cnt_q == CONV_CNT_W'(CONV_CYCLES - 1));
  assign lead_hit = (conv_cnt_q == CONV_CNT_W'(CONV_CYCLES - 1 - LEAD_CYCLES));
  assign rd_event = rd_tog_c ^ rd_tog_seen_q;
  assign do_update = (conv_wrap || upd_pend_q) && !busy_c;

  // Conversion period timer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_cnt_q <= '0;
    end
    else if (ce)
    begin
      conv_cnt_q <= conv_wrap ? '0 : conv_cnt_q + CONV_CNT_W'(1);
    end
  end

  // Result hold, deferred while a transfer runs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_hold_q <= '0;
      upd_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      if (do_update)
      begin
        data_hold_q <= conv_result;
        upd_pend_q <= 1'b0;
      end
      else if (conv_wrap)
      begin
        upd_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ready_n_q <= 1'b1;
      rd_tog_seen_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_tog_seen_q <= rd_tog_c;
      if (do_update)
      begin
        ready_n_q <= 1'b0;
      end
      else if (rd_event || lead_hit || (conv_wrap && busy_c))
      begin
        ready_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      powerdown_switch_q <= 1'b0;
    end
    else if (ce)
    begin
      powerdown_switch_q <= powerdown_switch_c;
    end
  end
  assign powerdown_switch = powerdown_switch_q;

  adcsp_clkpin u_clkpin (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .clock_source_select(clksel_c),
    .crystal_clock_pin_o(crystal_clock_pin_o),
    .crystal_clock_pin_oe(crystal_clock_pin_oe),
    .crystal_amp_en(crystal_amp_en),
    .ext_clk_sel(ext_clk_sel)
  );
endmodule : adcsp_top
`default_nettype wire

// ---- tb/adcsp_top_assertions.sv ----
// Purpose: Port checks for the converter serial port.
// Assumes: ce held high by the bench.
// Notes: Bound to adcsp_top below.
`timescale 1ns/100ps
`default_nettype none
module adcsp_top_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Serial pins
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  // Controls
  input wire logic powerdown_switch,
  input wire logic crystal_clock_pin_o,
  input wire logic crystal_clock_pin_oe,
  input wire logic crystal_amp_en,
  input wire logic ext_clk_sel
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [10:0] low_q;
  logic [10:0] high_q;
  // Length of the current low run on the line
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      low_q <= 11'h000;
    else if (dout_oe && !dout_o)
      low_q <= low_q + 11'h001;
    else
      low_q <= 11'h000;
  end
  // Length of the current high run on the line, saturating
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      high_q <= 11'h000;
    else if (!(dout_oe && dout_o))
      high_q <= 11'h000;
    else if (high_q != 11'h7FF)
      high_q <= high_q + 11'h001;
  end
  AST_TRISTATE: assert property (cs_n |-> !dout_oe)
    else $error("line driven while deselected");
  AST_DRIVE_SEL: assert property (!cs_n |-> dout_oe)
    else $error("line floats while selected");
  AST_ROLE_ONE: assert property ($onehot0({crystal_clock_pin_oe, crystal_amp_en, ext_clk_sel}))
    else $error("two pin roles at once");
  AST_CLKOUT_TOGGLE: assert property (ce && crystal_clock_pin_oe && $past(crystal_clock_pin_oe, 2)
    |-> crystal_clock_pin_o != $past(crystal_clock_pin_o))
    else $error("clock out not toggling");
  AST_CLKOUT_QUIET: assert property (!crystal_clock_pin_oe |-> !crystal_clock_pin_o)
    else $error("clock out active while off");
  AST_READY_LOW_MAX: assert property (low_q <= 11'h3C0)
    else $error("ready held low too long");
  AST_READY_RETURNS: assert property (high_q <= 11'h44C)
    else $error("no ready after update period");
  AST_POWERDOWN_SWITCH_IDLE: assert property ($changed(powerdown_switch) |-> cs_n)
    else $error("switch moved mid access");
  COV_READY: cover property (dout_oe ##1 !dout_o);
  COV_POWERDOWN_SWITCH: cover property ($rose(powerdown_switch));
  COV_CLKOUT: cover property ($rose(crystal_clock_pin_oe));
endmodule : adcsp_top_chk
bind adcsp_top adcsp_top_chk chk_i (.core_clk, .rst, .ce, .cs_n, .dout_o, .dout_oe, .powerdown_switch,
  .crystal_clock_pin_o, .crystal_clock_pin_oe, .crystal_amp_en, .ext_clk_sel);
`default_nettype wire

// ---- tb/adcsp_host.sv ----
// Purpose: Host serial master model.
// Assumes: 15 ns serial clock, idle high, still between frames.
// Notes: Bits change on falling, sampled on rising.
`timescale 1ns/100ps
`default_nettype none
module adcsp_host (
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial
  begin
    sclk = 1'h1;
    cs_n = 1'h1;
    din = 1'h0;
  end
  task automatic sel(input logic v);
    cs_n = v;
    #20;
  endtask : sel
  // Two serial clock cycles deselected after reset
  task automatic warm();
    repeat (2)
    begin
      sclk = 1'h0;
      #7.5;
      sclk = 1'h1;
      #7.5;
    end
  endtask : warm
  task automatic xfer(input logic [7:0] comm, input logic [23:0] wd, input int n, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {comm, wd << (24 - n)};
    rd = 24'h000000;
    cs_n = 1'h0;
    #10;
    for (int i = 0; i < 8 + n; i++)
    begin
      sclk = 1'h0;
      din = sh[31];
      sh = sh << 1;
      #7.5;
      // Sample just before rising, bit settled
      if (i >= 8)
        rd = {rd[22:0], dout};
      sclk = 1'h1;
      #7.5;
    end
    cs_n = 1'h1;
    din = ~din;
    #20;
  endtask : xfer
endmodule : adcsp_host
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model drives the serial pins.
// Notes: ce held high.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import adcsp_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic [WORD_W-1:0] conv_result = 24'hA5C31E;
  logic sclk, cs_n, din, dout_o, dout_oe, powerdown_switch;
  logic crystal_clock_pin_o, crystal_clock_pin_oe, crystal_amp_en, ext_clk_sel;
  wire dout_w;
  int err_total = 0;
  int comparisons = 0;
  logic [23:0] rd;
  assign dout_w = dout_oe ? dout_o : 1'hz;
  always #50 core_clk = ~core_clk;
  adcsp_top dut (.core_clk(core_clk), .rst(rst), .ce(ce), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_o(dout_o), .dout_oe(dout_oe), .conv_result(conv_result), .powerdown_switch(powerdown_switch),
    .crystal_clock_pin_o(crystal_clock_pin_o), .crystal_clock_pin_oe(crystal_clock_pin_oe),
    .crystal_amp_en(crystal_amp_en), .ext_clk_sel(ext_clk_sel));
  adcsp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_w));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic wfor(input logic v, output int n);
    n = 0;
    while (dout_w !== v && n < 1100)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : wfor
  task automatic t_reset();
    chk(24'({dout_oe, powerdown_switch, crystal_clock_pin_oe, crystal_amp_en, ext_clk_sel}), 24'h0);
    host.xfer({2'h1, ADDR_ID}, 24'h0, 16, rd);
    chk(rd, {8'h00, ID_VALUE});
    host.xfer(8'h87, {2'h1, ADDR_ID, 16'h0000}, 24, rd);
    chk({8'h00, rd[15:0]}, {8'h00, ID_VALUE});
    $display("reset test done");
  endtask : t_reset
  task automatic t_gpio();
    host.xfer({2'h0, ADDR_GPIO}, 24'h004000, 16, rd);
    repeat (6) @(negedge core_clk);
    chk(24'(powerdown_switch), 24'h1);
    host.xfer({2'h1, ADDR_GPIO}, 24'h0, 16, rd);
    chk(rd, 24'h004000);
    host.xfer({2'h0, ADDR_GPIO}, 24'h0, 16, rd);
    repeat (6) @(negedge core_clk);
    chk(24'(powerdown_switch), 24'h0);
    $display("gpio test done");
  endtask : t_gpio
  task automatic t_clk();
    logic prev;
    for (int s = 0; s < 4; s++)
    begin
      host.xfer({2'h0, ADDR_MODE}, 24'(s << MODE_CLKSEL_LSB), 16, rd);
      repeat (6) @(negedge core_clk);
      chk(24'({crystal_clock_pin_oe, crystal_amp_en, ext_clk_sel}), 24'(s == 1 ? 4 : s == 3 ? 2 : s == 2));
      prev = crystal_clock_pin_o;
      @(negedge core_clk);
      chk(24'(crystal_clock_pin_o), 24'(s == 1 ? !prev : 1'b0));
    end
    $display("clock test done");
  endtask : t_clk
  task automatic t_ready();
    int n;
    host.sel(1'h0);
    wfor(1'h0, n);
    chk(24'(n < 1100), 24'h1);
    host.xfer({2'h1, ADDR_DATA}, 24'h0, 24, rd);
    chk(rd, conv_result);
    host.xfer({2'h1, ADDR_STATUS}, 24'h0, 8, rd);
    chk(rd, 24'h000001 << STAT_RDY_BIT);
    host.sel(1'h0);
    repeat (10) @(negedge core_clk);
    chk(24'(dout_w), 24'h1);
    wfor(1'h0, n);
    wfor(1'h1, n);
    chk(24'(n < 960), 24'h1);
    wfor(1'h0, n);
    chk(24'(n >= 40 && n <= 60), 24'h1);
    host.sel(1'h1);
    $display("ready test done");
  endtask : t_ready
  initial
  begin
    #3000000;
    err_total++;
    summarize();
  end
  initial
  begin
    repeat (3) @(negedge core_clk);
    rst = 1'h0;
    host.warm();
    t_reset();
    t_gpio();
    t_clk();
    t_ready();
    summarize();
  end
endmodule : testbench
`default_nettype wire
